// File: rtl/icp_pkg.sv
// Package: register map, fields and timing constants of the interrupt controller
package icp_pkg;
    localparam int          ADDR_W          = 8;
    localparam logic [7:0]  OFF_CONTROL     = 8'h00;
    localparam logic [7:0]  OFF_STATUS      = 8'h04;
    localparam logic [7:0]  OFF_RELOAD      = 8'h08;
    localparam logic [7:0]  OFF_EVT_FLAGS   = 8'h0C;
    localparam logic [7:0]  OFF_EVT_MASK    = 8'h10;
    localparam logic [7:0]  OFF_PRIO        = 8'h14;
    localparam int          CTL_SHADOW_BIT  = 16;
    localparam int          CTL_MULTI_BIT   = 12;
    localparam int          CTL_THR_LSB     = 8;
    localparam int          CTL_POL_LSB     = 0;
    localparam logic [31:0] CTL_WMASK       = 32'h0001_171F;
    localparam int          STS_PRIO_LSB    = 8;
    localparam int          STS_NUM_LSB     = 0;
    localparam logic [31:0] RESET_WORD      = 32'h0000_0000;
    localparam int          N_EXT           = 5;
    localparam int          N_SRC           = 8;
    localparam int          PRIO_W          = 3;
    localparam int          NUM_W           = 6;
    localparam int          N_EVT           = 2;
    localparam int          EVT_PRESENT     = 0;
    localparam int          EVT_PROX_DONE   = 1;
    localparam logic [2:0]  PRIO_OFF        = 3'h0;
    localparam logic [31:0] TIMER_ONE       = 32'h0000_0001;
    typedef enum logic [1:0] {
        ICP_IDLE = 2'b01,
        ICP_HOLD = 2'b10
    } icp_prox_e;
endpackage : icp_pkg

// File: rtl/icp_edge_detect.sv
// Polarity-selectable edge detectors for the external interrupt inputs
`timescale 1ns/10ps
`default_nettype none
module icp_edge_detect #(
    parameter int N = 5
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic [N-1:0] pins,
    input  wire logic [N-1:0] rising,
    output logic      [N-1:0] hit
);
    logic [N-1:0] last;

    always_ff @(posedge clk) begin
        if (reset) begin
            last <= '0;
        end else begin
            last <= pins;
        end
    end

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_edge
            // 1 selects rising, 0 falling
            assign hit[g] = rising[g] ? (pins[g] & ~last[g])
                                      : (~pins[g] & last[g]);
        end
    endgenerate
endmodule : icp_edge_detect
`default_nettype wire

// File: rtl/icp_select.sv
// Picks the highest-priority pending source; priority 0 never wins
`timescale 1ns/10ps
`default_nettype none
module icp_select #(
    parameter int N  = 8,
    parameter int PW = 3,
    parameter int NW = 6
) (
    input  wire logic [N-1:0]    pend,
    input  wire logic [N*PW-1:0] prio,
    output logic                 found,
    output logic [PW-1:0]        best_prio,
    output logic [NW-1:0]        best_num
);
    always_comb begin
        found     = 1'b0;
        best_prio = '0;
        best_num  = '0;
        for (int i = 0; i < N; i++) begin
            // Strictly greater keeps the lowest number on ties
            if (pend[i] && prio[i*PW +: PW] > best_prio) begin
                found     = 1'b1;
                best_prio = prio[i*PW +: PW];
                best_num  = NW'(i);
            end
        end
    end
endmodule : icp_select
`default_nettype wire

// File: rtl/icp_ctrl.sv
// Interrupt controller configuration, status and proximity timer block
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
module icp_ctrl
    import icp_pkg::*;
#(
    parameter int N_SOURCES = icp_pkg::N_SRC
) (
    input  wire logic                                 CLK,
    input  wire logic                                 RESET,
    input  wire logic                                 PSEL,
    input  wire logic                                 PENABLE,
    input  wire logic                                 PWRITE,
    input  wire logic [icp_pkg::ADDR_W-1:0]           PADDR,
    input  wire logic [31:0]                          PWDATA,
    input  wire logic [3:0]                           PSTRB,
    output logic      [31:0]                          PRDATA,
    output logic                                      PREADY,
    output logic                                      PSLVERR,
    input  wire logic [icp_pkg::N_EXT-1:0]            EXT_IRQ,
    input  wire logic [N_SOURCES-1:0]                 SRC_REQ,
    input  wire logic                                 CPU_ACK,
    output logic                                      CPU_IRQ,
    output logic      [icp_pkg::NUM_W-1:0]            CPU_IRQ_NUM,
    output logic      [icp_pkg::PRIO_W-1:0]           CPU_IRQ_PRIO,
    output logic                                      CPU_SHADOW,
    output logic                                      MULTI_MODE,
    output logic                                      IRQ
);
    import icp_pkg::*;

    localparam int NE = N_EXT;
    localparam int NS = N_SOURCES;

    logic [31:0]          irq_control_reg;
    logic [31:0]          proximity_reload_value;
    logic [NS*PRIO_W-1:0] group_priority_field;
    logic [NS-1:0]        request_flag;
    logic [N_EVT-1:0]     evt_flags;
    logic [N_EVT-1:0]     evt_mask;
    logic [PRIO_W-1:0]    presented_priority_level;
    logic [NUM_W-1:0]     presented_irq_number;
    logic [31:0]          prox_count;
    icp_prox_e            prox_state;
    logic [NE-1:0]        ext_hit;
    logic                 found;
    logic [PRIO_W-1:0]    best_prio;
    logic [NUM_W-1:0]     best_num;
    logic [31:0]          wmask;

    ////////////////////////////////////////////////////////////////////////
    // Control field views

    logic                 single_mode_shadow_set;
    logic                 multi_handler_mode;
    logic [PRIO_W-1:0]    proximity_threshold_sel;
    logic [NE-1:0]        ext_edge_pol;

    assign single_mode_shadow_set  = irq_control_reg[CTL_SHADOW_BIT];
    assign multi_handler_mode      = irq_control_reg[CTL_MULTI_BIT];
    assign proximity_threshold_sel =
        irq_control_reg[CTL_THR_LSB +: PRIO_W];
    assign ext_edge_pol            = irq_control_reg[CTL_POL_LSB +: NE];

    ////////////////////////////////////////////////////////////////////////
    // APB slave: zero wait states, unmapped addresses answer with an error

    logic wr_en;
    logic rd_en;

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        return (a == OFF_CONTROL) || (a == OFF_STATUS) ||
               (a == OFF_RELOAD) || (a == OFF_EVT_FLAGS) ||
               (a == OFF_EVT_MASK) || (a == OFF_PRIO);
    endfunction : mapped

    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~mapped(PADDR);
    assign wr_en   = PSEL & PENABLE & PWRITE & mapped(PADDR);
    assign rd_en   = PSEL & ~PENABLE & ~PWRITE;

    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wmask[b*8 +: 8] = {8{PSTRB[b]}};
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            irq_control_reg        <= RESET_WORD;
            proximity_reload_value <= RESET_WORD;
            evt_mask               <= '0;
            group_priority_field   <= '0;
        end else if (wr_en) begin
            if (PADDR == OFF_CONTROL) begin
                // Only implemented bits ever store a one
                irq_control_reg <= (irq_control_reg & ~(wmask & CTL_WMASK))
                                 | (PWDATA & wmask & CTL_WMASK);
            end else if (PADDR == OFF_RELOAD) begin
                proximity_reload_value <= (proximity_reload_value & ~wmask)
                                        | (PWDATA & wmask);
            end else if (PADDR == OFF_EVT_MASK) begin
                if (PSTRB[0]) begin
                    evt_mask <= PWDATA[N_EVT-1:0];
                end
            end else if (PADDR == OFF_PRIO) begin
                group_priority_field <= PWDATA[NS*PRIO_W-1:0];
            end
        end
    end

    // Read data registered in the setup cycle, valid in the access phase
    always_ff @(posedge CLK) begin
        if (RESET) begin
            PRDATA <= '0;
        end else if (rd_en) begin
            if (PADDR == OFF_CONTROL) begin
                PRDATA <= irq_control_reg;
            end else if (PADDR == OFF_STATUS) begin
                // Only priority and number fields; rest reads zero
                PRDATA <= {21'h0, presented_priority_level,
                           2'h0, presented_irq_number};
            end else if (PADDR == OFF_RELOAD) begin
                PRDATA <= proximity_reload_value;
            end else if (PADDR == OFF_EVT_FLAGS) begin
                PRDATA <= {{(32-N_EVT){1'b0}}, evt_flags};
            end else if (PADDR == OFF_EVT_MASK) begin
                PRDATA <= {{(32-N_EVT){1'b0}}, evt_mask};
            end else if (PADDR == OFF_PRIO) begin
                PRDATA <= {{(32-NS*PRIO_W){1'b0}}, group_priority_field};
            end else begin
                PRDATA <= '0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Request flags: external edges feed the low sources

    icp_edge_detect #(
        .N      (NE)
    ) u_edge (
        .clk    (CLK),
        .reset  (RESET),
        .pins   (EXT_IRQ),
        .rising (ext_edge_pol),
        .hit    (ext_hit)
    );

    logic [NS-1:0] raise;
    logic [NS-1:0] ack_clear;
    logic          present;

    assign raise = SRC_REQ | NS'(ext_hit);

    always_comb begin
        ack_clear = '0;
        if (CPU_ACK && CPU_IRQ) begin
            ack_clear[best_num[$clog2(NS)-1:0]] = 1'b1;
        end
    end

    // A new request in the acknowledge cycle wins over the clear
    always_ff @(posedge CLK) begin
        if (RESET) begin
            request_flag <= '0;
        end else begin
            request_flag <= (request_flag & ~ack_clear) | raise;
        end
    end

    icp_select #(
        .N         (NS),
        .PW        (PRIO_W),
        .NW        (NUM_W)
    ) u_sel (
        .pend      (request_flag),
        .prio      (group_priority_field),
        .found     (found),
        .best_prio (best_prio),
        .best_num  (best_num)
    );

    ////////////////////////////////////////////////////////////////////////
    // Proximity timer

    logic qualify;

    // 000 never qualifies; else any priority up to the code
    assign qualify = found && (proximity_threshold_sel != PRIO_OFF)
                  && (best_prio <= proximity_threshold_sel);

    always_ff @(posedge CLK) begin
        if (RESET) begin
            prox_state <= ICP_IDLE;
            prox_count <= '0;
        end else begin
            case (prox_state)
                ICP_IDLE: begin
                    if (qualify && !CPU_IRQ) begin
                        prox_count <= proximity_reload_value;
                        prox_state <= ICP_HOLD;
                    end
                end
                ICP_HOLD: begin
                    // Disabling mid-count releases held requests at once
                    if (proximity_threshold_sel == PRIO_OFF ||
                        prox_count <= TIMER_ONE) begin
                        prox_state <= ICP_IDLE;
                    end else begin
                        prox_count <= prox_count - TIMER_ONE;
                    end
                end
                default: prox_state <= ICP_IDLE;
            endcase
        end
    end

    logic released;
    assign released = (prox_state == ICP_HOLD) &&
                      (proximity_threshold_sel == PRIO_OFF ||
                       prox_count <= TIMER_ONE);

    // Hold back qualifying work while counting
    assign present = found && !qualify;

    ////////////////////////////////////////////////////////////////////////
    // CPU presentation

    // Once released, keep presenting until every pending source is taken;
    // a one-cycle window would let the same request restart the timer
    logic present_q;
    always_ff @(posedge CLK) begin
        if (RESET) begin
            present_q <= 1'b0;
        end else begin
            present_q <= released || (present_q && found);
        end
    end

    assign CPU_IRQ = (prox_state == ICP_IDLE) &&
                     (present || (found && present_q));

    always_ff @(posedge CLK) begin
        if (RESET) begin
            presented_priority_level <= '0;
            presented_irq_number     <= '0;
            CPU_IRQ_NUM              <= '0;
            CPU_IRQ_PRIO             <= '0;
        end else if (found && (prox_state == ICP_IDLE)) begin
            presented_priority_level <= best_prio;
            presented_irq_number     <= best_num;
            CPU_IRQ_NUM              <= best_num;
            CPU_IRQ_PRIO             <= best_prio;
        end
    end

    // Shadow set only applies to the single shared entry
    assign CPU_SHADOW = single_mode_shadow_set & ~multi_handler_mode;
    assign MULTI_MODE = multi_handler_mode;

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status, write one to clear; a new event wins

    logic [N_EVT-1:0] evt_set;
    logic [N_EVT-1:0] evt_clr;
    assign evt_set[EVT_PRESENT]   = CPU_IRQ & CPU_ACK;
    assign evt_set[EVT_PROX_DONE] = released;
    assign evt_clr = (wr_en && PADDR == OFF_EVT_FLAGS && PSTRB[0])
                   ? PWDATA[N_EVT-1:0] : '0;

    always_ff @(posedge CLK) begin
        if (RESET) begin
            evt_flags <= '0;
        end else begin
            evt_flags <= (evt_flags & ~evt_clr) | evt_set;
        end
    end

    assign IRQ = |(evt_flags & evt_mask);

    ////////////////////////////////////////////////////////////////////////
    // Checks

    AST_THR_OFF_NO_START: assert property (@(posedge CLK) disable iff (RESET)
        (proximity_threshold_sel == PRIO_OFF && prox_state == ICP_IDLE)
        |=> prox_state == ICP_IDLE)
        else $error("Timer started with threshold off");
    AST_LOAD_RELOAD: assert property (@(posedge CLK) disable iff (RESET)
        (prox_state == ICP_IDLE && qualify && !CPU_IRQ)
        |=> prox_count == $past(proximity_reload_value))
        else $error("Timer not loaded from reload value");
    AST_QUALIFY_LEVEL: assert property (@(posedge CLK) disable iff (RESET)
        (prox_state == ICP_IDLE && found && !CPU_IRQ
         && proximity_threshold_sel != PRIO_OFF
         && best_prio <= proximity_threshold_sel)
        |=> prox_state == ICP_HOLD)
        else $error("Qualifying interrupt did not start timer");
    AST_RELEASE_PRESENTS: assert property (@(posedge CLK) disable iff (RESET)
        (released && found) |=> CPU_IRQ ##1 (CPU_IRQ || !found))
        else $error("Released interrupt not kept presented");
    AST_NO_PRIO_ZERO: assert property (@(posedge CLK) disable iff (RESET)
        CPU_IRQ |-> best_prio != PRIO_OFF)
        else $error("Disabled source presented");
    AST_HOLD_BLOCKS: assert property (@(posedge CLK) disable iff (RESET)
        prox_state == ICP_HOLD |-> !CPU_IRQ)
        else $error("Interrupt presented while timer runs");
    AST_COUNT_DOWN: assert property (@(posedge CLK) disable iff (RESET)
        (prox_state == ICP_HOLD && !released)
        |=> prox_count == $past(prox_count) - TIMER_ONE)
        else $error("Proximity count did not decrement");
    AST_STATUS_TRACK: assert property (@(posedge CLK) disable iff (RESET)
        (found && prox_state == ICP_IDLE)
        |=> presented_irq_number == $past(best_num)
            && presented_priority_level == $past(best_prio))
        else $error("Status fields not updated");
    AST_CTL_RESERVED: assert property (@(posedge CLK) disable iff (RESET)
        (irq_control_reg & ~CTL_WMASK) == 32'h0000_0000)
        else $error("Unimplemented control bit set");
    AST_SHADOW_MODE: assert property (@(posedge CLK) disable iff (RESET)
        CPU_SHADOW |-> irq_control_reg[CTL_SHADOW_BIT]
                       && !irq_control_reg[CTL_MULTI_BIT])
        else $error("Shadow set outside single mode");
    AST_FLAG_SET: assert property (@(posedge CLK) disable iff (RESET)
        raise[0] |=> request_flag[0])
        else $error("Request flag not set");

    COV_TIMER_RUN: cover property (@(posedge CLK) disable iff (RESET)
        prox_state == ICP_HOLD ##1 released);
    COV_PRESENT: cover property (@(posedge CLK) disable iff (RESET)
        CPU_IRQ && CPU_ACK);
    COV_EXT_EDGE: cover property (@(posedge CLK) disable iff (RESET)
        |ext_hit);
endmodule : icp_ctrl
`default_nettype wire

// File: dv/icp_cpu_model.sv
// Behavioural CPU core: takes each presented interrupt after a set wait
`timescale 1ns/10ps
`default_nettype none
module icp_cpu_model
    import icp_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    reset,
    input  wire logic                    irq,
    input  wire logic [icp_pkg::NUM_W-1:0]  irq_num,
    input  wire logic [icp_pkg::PRIO_W-1:0] irq_prio,
    input  wire logic [3:0]              wait_cycles,
    output logic                         ack,
    output logic      [icp_pkg::NUM_W-1:0]  last_num,
    output logic      [icp_pkg::PRIO_W-1:0] last_prio,
    output logic      [7:0]              n_taken
);
    import icp_pkg::*;
    logic [3:0] cnt;
    ////////////////////////////////////////////////////////////////////////
    // Waits wait_cycles cycles; one or more lets the registered number settle;
    // a long wait models a core busy with a higher task
    always_ff @(posedge clk) begin
        if (reset) begin
            cnt       <= 4'h0;
            ack       <= 1'b0;
            last_num  <= '0;
            last_prio <= '0;
            n_taken   <= 8'h00;
        end else begin
            ack <= 1'b0;
            if (irq && !ack) begin
                if (cnt >= wait_cycles) begin
                    ack       <= 1'b1;
                    last_num  <= irq_num;
                    last_prio <= irq_prio;
                    n_taken   <= n_taken + 8'h01;
                    cnt       <= 4'h0;
                end else begin
                    cnt <= cnt + 4'h1;
                end
            end else begin
                cnt <= 4'h0;
            end
        end
    end
endmodule : icp_cpu_model
`default_nettype wire

// File: dv/testbench.sv
// Self-checking bench for the interrupt controller block
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import icp_pkg::*;
    typedef struct {
        logic [2:0] thr;
        int         src;
        logic [2:0] prio;
        bit         held;
    } icp_row_s;
    logic        clk, reset, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, src_req, n_taken, b;
    logic [31:0] pwdata, prdata, r;
    logic [4:0]  ext_irq;
    logic        cpu_ack, cpu_irq, cpu_shadow, multi_mode, irq, e;
    logic [5:0]  irq_num, last_num;
    logic [2:0]  irq_prio, last_prio;
    logic [3:0]  wait_cycles;
    int          n_mismatch = 0;
    int          checks_done = 0;
    int          cyc;
    logic [7:0]  offs[6] = '{OFF_CONTROL, OFF_STATUS, OFF_RELOAD,
                             OFF_EVT_FLAGS, OFF_EVT_MASK, OFF_PRIO};
    icp_row_s    rows[6] = '{'{3'h0, 5, 3'h7, 1'b0}, '{3'h1, 2, 3'h1, 1'b1},
                             '{3'h1, 3, 3'h2, 1'b0}, '{3'h2, 6, 3'h2, 1'b1},
                             '{3'h2, 7, 3'h3, 1'b0}, '{3'h7, 4, 3'h7, 1'b1}};
    icp_ctrl icp_ctrl_i (.CLK(clk), .RESET(reset), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PSTRB(4'hF), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .EXT_IRQ(ext_irq), .SRC_REQ(src_req), .CPU_ACK(cpu_ack),
        .CPU_IRQ(cpu_irq), .CPU_IRQ_NUM(irq_num), .CPU_IRQ_PRIO(irq_prio),
        .CPU_SHADOW(cpu_shadow), .MULTI_MODE(multi_mode), .IRQ(irq));
    icp_cpu_model icp_cpu_model_i (.clk(clk), .reset(reset), .irq(cpu_irq),
        .irq_num(irq_num), .irq_prio(irq_prio), .wait_cycles(wait_cycles),
        .ack(cpu_ack), .last_num(last_num), .last_prio(last_prio),
        .n_taken(n_taken));
    always #50 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // Entered just after a rising edge; holds the request until pready
    task automatic apb(input logic wr_en, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic err);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr_en;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (n == 20) check("pready", 32'h1, 32'h0);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, r, e);
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp,
                         input string what);
        apb(1'b0, a, 32'h0, r, e);
        check(what, exp, r);
    endtask : rdchk
    task automatic wait_taken(input logic [7:0] base, input int lim);
        cyc = 0;
        while (n_taken === base && cyc < lim) begin
            @(posedge clk);
            cyc++;
        end
    endtask : wait_taken
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #2000000;
        n_mismatch++;
        $display("watchdog expired");
        finish_test();
    end
    initial begin
        clk = 0; reset = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0;
        pwdata = 0; ext_irq = 0; src_req = 0; wait_cycles = 4'h2;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        foreach (offs[k]) rdchk(offs[k], RESET_WORD, "reset value");
        // Table of ordinary interrupt cases, fast and slow core in turn
        wr(OFF_RELOAD, 32'd40);
        foreach (rows[i]) begin
            wait_cycles <= (i % 2) ? 4'h6 : 4'h2;
            wr(OFF_CONTROL, {21'h0, rows[i].thr, 8'h00});
            wr(OFF_PRIO, 32'(rows[i].prio) << (3 * rows[i].src));
            b = n_taken;
            src_req[rows[i].src] <= 1'b1;
            @(posedge clk);
            src_req <= 8'h00;
            cyc = 0;
            while (cpu_irq !== 1'b1 && cyc < 60) begin
                @(posedge clk);
                cyc++;
            end
            if (rows[i].held)
                check("held", 1, cyc >= 30 && cyc <= 48);
            else
                check("prompt", 1, cyc <= 4);
            wait_taken(b, 20);
            check("taken", b + 8'h01, n_taken);
            rdchk(OFF_STATUS, {21'h0, rows[i].prio, 2'b00, 6'(rows[i].src)},
                  "status");
        end
        $display("test table done");
        // Field masks, read-only and unmapped places; a quick core from here
        wait_cycles <= 4'h2;
        wr(OFF_EVT_FLAGS, 32'h3);
        wr(OFF_EVT_MASK, 32'h0);
        wr(OFF_CONTROL, 32'hFFFF_FFFF);
        rdchk(OFF_CONTROL, CTL_WMASK, "control");
        check("multi", 1, multi_mode);
        check("shadow", 0, cpu_shadow);
        wr(OFF_CONTROL, 32'h0001_0000);
        check("multi", 0, multi_mode);
        check("shadow", 1, cpu_shadow);
        wr(OFF_STATUS, 32'hFFFF_FFFF);
        rdchk(OFF_STATUS, 32'h0000_0704, "status ro");
        wr(OFF_RELOAD, 32'hA5C3_5A3C);
        rdchk(OFF_RELOAD, 32'hA5C3_5A3C, "reload");
        apb(1'b1, 8'h40, 32'hFFFF_FFFF, r, e);
        check("slverr", 1, e);
        apb(1'b0, 8'h40, 32'h0, r, e);
        check("unmapped", 32'h0, r);
        check("slverr", 1, e);
        $display("test registers done");
        // Disabled priority keeps the flag, which later wins
        wr(OFF_CONTROL, 32'h0);
        wr(OFF_PRIO, 32'h0);
        b = n_taken;
        src_req[5] <= 1'b1;
        @(posedge clk);
        src_req <= 8'h00;
        wait_taken(b, 8);
        check("disabled", 8, cyc);
        check("no irq", 0, cpu_irq);
        wr(OFF_PRIO, 32'h3 << 15);
        wait_taken(b, 8);
        check("flag kept", 1, cyc < 8);
        check("number", 5, last_num);
        $display("test disabled done");
        // Event flags, mask and interrupt line
        wr(OFF_EVT_MASK, 32'h3);
        check("irq on", 1, irq);
        rdchk(OFF_EVT_FLAGS, 32'h1, "flags");
        wr(OFF_EVT_MASK, 32'h2);
        check("irq masked", 0, irq);
        wr(OFF_EVT_MASK, 32'h1);
        wr(OFF_EVT_FLAGS, 32'h1);
        check("irq cleared", 0, irq);
        rdchk(OFF_EVT_FLAGS, 32'h0, "flags");
        $display("test events done");
        // Each external pin under both polarities
        wr(OFF_PRIO, 32'h0000_4924);
        for (int i = 0; i < 5; i++) begin
            for (int p = 1; p >= 0; p--) begin
                wr(OFF_CONTROL, 32'(p) << i);
                b = n_taken;
                ext_irq[i] <= 1'b1;
                @(posedge clk);
                wait_taken(b, 8);
                check("rise", p, cyc < 8);
                b = n_taken;
                ext_irq[i] <= 1'b0;
                @(posedge clk);
                wait_taken(b, 8);
                check("fall", !p, cyc < 8);
                check("ext number", i, last_num);
                check("ext prio", 4, last_prio);
            end
        end
        $display("test edges done");
        // Reset in mid-run
        wr(OFF_CONTROL, 32'h0001_171F);
        wr(OFF_RELOAD, 32'h5);
        // Reset lands while the timer holds a pending request
        src_req[0] <= 1'b1;
        @(posedge clk);
        src_req <= 8'h00;
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rdchk(OFF_CONTROL, 32'h0, "control");
        rdchk(OFF_RELOAD, 32'h0, "reload");
        check("shadow", 0, cpu_shadow);
        rdchk(OFF_STATUS, 32'h0, "status");
        rdchk(OFF_PRIO, 32'h0, "priority");
        rdchk(OFF_EVT_FLAGS, 32'h0, "flags");
        check("cpu irq", 0, cpu_irq);
        check("irq", 0, irq);
        $display("test reset done");
        finish_test();
    end
endmodule : testbench
`default_nettype wire
